// ===== crs_pkg.sv
/*
 * Shared constants and types for the counter read-snapshot pair.
 * Assumes both ends run on one 10 MHz clock with a synchronous reset.
 */
package crs_pkg;
	localparam int CHANNELS         = 2;
	localparam int CNT_W            = 8;
	localparam int CH_TWO           = 0;
	localparam int CH_FOUR          = 1;
	localparam int OSC_DIV          = 4;
	localparam int OSC_DIV_W        = 2;
	localparam logic [OSC_DIV_W-1:0] OSC_DIV_LAST = 2'h3;
	localparam int CLK_PERIOD_NS    = 100;
	localparam int STOP_SETTLE_NS   = 300;
	localparam int STOP_SETTLE_CYC  = (STOP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W         = 3;
	localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(STOP_SETTLE_CYC);
	localparam logic [CNT_W-1:0]    CNT_ZERO    = 8'h00;
	localparam logic [CNT_W-1:0]    CNT_ONE     = 8'h01;
	localparam int RESET_SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		CRS_STOP_NONE = 2'h0,
		CRS_STOP_OSC  = 2'h1,
		CRS_STOP_SRC  = 2'h2,
		CRS_STOP_LUT  = 2'h3
	} crs_stop_t;

	typedef enum logic [2:0] {
		CRS_H_IDLE   = 3'h0,
		CRS_H_STOP   = 3'h1,
		CRS_H_SETTLE = 3'h2,
		CRS_H_REQ    = 3'h3,
		CRS_H_WAIT   = 3'h4,
		CRS_H_RESUME = 3'h5
	} crs_host_state_t;
endpackage : crs_pkg

// ===== crs_link_if.sv
/*
 * Link between the counter device end and the reading host end.
 * Assumes both ends share clk; no signal here needs a crossing.
 */
`timescale 1ns/10ps
`default_nettype none
interface crs_link_if;
	import crs_pkg::*;
	logic                osc_pwr_down;
	logic [CHANNELS-1:0] clk_src_mtx;
	logic [CHANNELS-1:0] mtx_en;
	logic [CHANNELS-1:0] mtx_tick;
	logic [CHANNELS-1:0] cnt_reset;
	logic                rd_req;
	logic                rd_sel;
	logic [CNT_W-1:0]    rd_data;
	logic                rd_valid;
	logic [CHANNELS-1:0] cnt_out;

	modport dev (
		input  osc_pwr_down, clk_src_mtx, mtx_en, mtx_tick, cnt_reset, rd_req, rd_sel,
		output rd_data, rd_valid, cnt_out
	);
	modport host (
		output osc_pwr_down, clk_src_mtx, mtx_en, mtx_tick, cnt_reset, rd_req, rd_sel,
		input  rd_data, rd_valid, cnt_out
	);
endinterface : crs_link_if
`default_nettype wire

// ===== crs_device_end.sv
/*
 * Device end: oscillator divider, two 8-bit down counters and the
 * read-back snapshot register returned to the host.
 * Assumes the link inputs come from logic on the same clk, already
 * synchronized by the host end.
 */
`timescale 1ns/10ps
`default_nettype none

//
// Overview of operation
// - Reset beats a coincident tick, reloading cleanly
// - Host syncs counter reset through two flops
// - Read request latches live count for host
// - Snapshot never sees a half-updated count
// - Counting continues untouched by snapshot activity
// - Two 8-bit counter instances are readable
// - Stopped clock gives exact count every read
// - Matrix source with input unused grounds clock
// - Oscillator power-down halts the counter clock
// - Host gates the selected channel's matrix clock during LUT-mode reads
// - Stopped ticks stretch the counter period
module crs_device_end (
	input  wire logic                                 clk,
	input  wire logic                                 reset,
	crs_link_if.dev                                   link,
	input  wire logic [crs_pkg::CHANNELS-1:0][crs_pkg::CNT_W-1:0] period,
	output var  logic [crs_pkg::CHANNELS-1:0][crs_pkg::CNT_W-1:0] count_value
);
	import crs_pkg::*;

	logic [OSC_DIV_W-1:0] osc_div_ff;
	logic [OSC_DIV_W-1:0] nxt_osc_div;
	logic                 osc_tick_ff;
	logic                 nxt_osc_tick;

	logic [CHANNELS-1:0][CNT_W-1:0] count_ff;
	logic [CHANNELS-1:0][CNT_W-1:0] nxt_count;
	logic [CHANNELS-1:0]            out_ff;
	logic [CHANNELS-1:0]            nxt_out;
	logic [CHANNELS-1:0]            tick;

	logic             latch_ff;
	logic             nxt_latch;
	logic             latch_sel_ff;
	logic             nxt_latch_sel;
	logic [CNT_W-1:0] snap_ff;
	logic [CNT_W-1:0] nxt_snap;
	logic             valid_ff;
	logic             nxt_valid;

	// Oscillator divider
	always_comb begin
		nxt_osc_div  = osc_div_ff;
		nxt_osc_tick = 1'b0;
		if (!link.osc_pwr_down) begin
			if (osc_div_ff == OSC_DIV_LAST) begin
				nxt_osc_div  = '0;
				nxt_osc_tick = 1'b1;
			end else begin
				nxt_osc_div = osc_div_ff + 2'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			osc_div_ff  <= '0;
			osc_tick_ff <= 1'b0;
		end else begin
			osc_div_ff  <= nxt_osc_div;
			osc_tick_ff <= nxt_osc_tick;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_cnt
			assign tick[gi] = link.clk_src_mtx[gi] ? (link.mtx_en[gi] & link.mtx_tick[gi])
			                                       : osc_tick_ff;

			always_comb begin
				nxt_count[gi] = count_ff[gi];
				nxt_out[gi]   = 1'b0;
				if (link.cnt_reset[gi]) begin
					nxt_count[gi] = period[gi];
				end else if (tick[gi]) begin
					if (count_ff[gi] == CNT_ZERO) begin
						nxt_count[gi] = period[gi];
						nxt_out[gi]   = 1'b1;
					end else begin
						nxt_count[gi] = count_ff[gi] - CNT_ONE;
					end
				end
			end

			always_ff @(posedge clk) begin
				if (reset) begin
					count_ff[gi] <= CNT_ZERO;
					out_ff[gi]   <= 1'b0;
				end else begin
					count_ff[gi] <= nxt_count[gi];
					out_ff[gi]   <= nxt_out[gi];
				end
			end

			assign count_value[gi] = count_ff[gi];
		end
	endgenerate

	assign link.cnt_out = out_ff;

	// Snapshot path
	always_comb begin
		nxt_latch     = 1'b0;
		nxt_latch_sel = latch_sel_ff;
		nxt_snap      = snap_ff;
		nxt_valid     = 1'b0;
		if (link.rd_req) begin
			nxt_latch     = 1'b1;
			nxt_latch_sel = link.rd_sel;
		end
		if (latch_ff) begin
			nxt_snap  = count_ff[latch_sel_ff];
			nxt_valid = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			latch_ff     <= 1'b0;
			latch_sel_ff <= 1'b0;
			snap_ff      <= CNT_ZERO;
			valid_ff     <= 1'b0;
		end else begin
			latch_ff     <= nxt_latch;
			latch_sel_ff <= nxt_latch_sel;
			snap_ff      <= nxt_snap;
			valid_ff     <= nxt_valid;
		end
	end

	// data stands until the next read
	assign link.rd_data  = snap_ff;
	assign link.rd_valid = valid_ff;
endmodule : crs_device_end
`default_nettype wire

// ===== crs_host_end.sv
/*
 * Host end: synchronizes counter resets and external clocks, stops the
 * counter clock in the chosen way, then reads one count value.
 * Assumes reset_pin and ext_clk_pin come from outside the clk domain.
 */
`timescale 1ns/10ps
`default_nettype none
module crs_host_end (
	input  wire logic                          clk,
	input  wire logic                          reset,
	crs_link_if.host                           link,
	input  wire logic                          start,
	input  wire logic                          sel,
	input  wire crs_pkg::crs_stop_t            stop_mode,
	input  wire logic [crs_pkg::CHANNELS-1:0]  src_mtx_cfg,
	input  wire logic [crs_pkg::CHANNELS-1:0]  mtx_en_cfg,
	input  wire logic [crs_pkg::CHANNELS-1:0]  ext_clk_pin,
	input  wire logic [crs_pkg::CHANNELS-1:0]  reset_pin,
	output var  logic                          busy,
	output var  logic                          done,
	output var  logic [crs_pkg::CNT_W-1:0]     value
);
	import crs_pkg::*;

	crs_host_state_t     state_ff;
	crs_host_state_t     nxt_state;
	logic [SETTLE_W-1:0] settle_ff;
	logic [SETTLE_W-1:0] nxt_settle;
	crs_stop_t           mode_ff;
	crs_stop_t           nxt_mode;
	logic                sel_ff;
	logic                nxt_sel;
	logic                req_ff;
	logic                nxt_req;
	logic                busy_ff;
	logic                nxt_busy;
	logic                done_ff;
	logic                nxt_done;
	logic [CNT_W-1:0]    value_ff;
	logic [CNT_W-1:0]    nxt_value;
	logic                pwr_ff;
	logic                nxt_pwr;
	logic [CHANNELS-1:0] src_ff;
	logic [CHANNELS-1:0] nxt_src;
	logic [CHANNELS-1:0] en_ff;
	logic [CHANNELS-1:0] nxt_en;
	logic [CHANNELS-1:0] gate;

	logic [CHANNELS-1:0][RESET_SYNC_STAGES-1:0] rst_sync_ff;
	logic [CHANNELS-1:0][RESET_SYNC_STAGES-1:0] nxt_rst_sync;
	logic [CHANNELS-1:0][2:0]                   clk_sync_ff;
	logic [CHANNELS-1:0][2:0]                   nxt_clk_sync;
	logic [CHANNELS-1:0]                        tick_ff;
	logic [CHANNELS-1:0]                        nxt_tick;

	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_pin
			assign gate[gi] = (mode_ff == CRS_STOP_LUT) && (sel_ff == 1'(gi)) && busy_ff;

			always_comb begin
				nxt_rst_sync[gi] = {rst_sync_ff[gi][0], reset_pin[gi]};
				nxt_clk_sync[gi] = {clk_sync_ff[gi][1:0], ext_clk_pin[gi]};
				nxt_tick[gi]     = clk_sync_ff[gi][1] & ~clk_sync_ff[gi][2] & ~gate[gi];
			end

			always_ff @(posedge clk) begin
				if (reset) begin
					rst_sync_ff[gi] <= '0;
					clk_sync_ff[gi] <= '0;
					tick_ff[gi]     <= 1'b0;
				end else begin
					rst_sync_ff[gi] <= nxt_rst_sync[gi];
					clk_sync_ff[gi] <= nxt_clk_sync[gi];
					tick_ff[gi]     <= nxt_tick[gi];
				end
			end

			assign link.cnt_reset[gi] = rst_sync_ff[gi][RESET_SYNC_STAGES-1];
		end
	endgenerate

	always_comb begin
		nxt_state  = state_ff;
		nxt_settle = settle_ff;
		nxt_mode   = mode_ff;
		nxt_sel    = sel_ff;
		nxt_req    = 1'b0;
		nxt_busy   = busy_ff;
		nxt_done   = 1'b0;
		nxt_value  = value_ff;
		nxt_pwr    = pwr_ff;
		nxt_src    = src_mtx_cfg;
		nxt_en     = mtx_en_cfg;
		if (busy_ff && mode_ff == CRS_STOP_SRC) begin
			nxt_src[sel_ff] = 1'b1;
			nxt_en[sel_ff]  = 1'b0;
		end
		case (state_ff)
			CRS_H_IDLE: begin
				if (start) begin
					nxt_mode  = stop_mode;
					nxt_sel   = sel;
					nxt_busy  = 1'b1;
					nxt_state = CRS_H_STOP;
				end
			end
			CRS_H_STOP: begin
				nxt_pwr    = (mode_ff == CRS_STOP_OSC);
				nxt_settle = SETTLE_LOAD;
				nxt_state  = (mode_ff == CRS_STOP_NONE) ? CRS_H_REQ : CRS_H_SETTLE;
			end
			CRS_H_SETTLE: begin
				nxt_settle = settle_ff - 3'h1;
				if (settle_ff == 3'h1) begin
					nxt_state = CRS_H_REQ;
				end
			end
			CRS_H_REQ: begin
				nxt_req   = 1'b1;
				nxt_state = CRS_H_WAIT;
			end
			CRS_H_WAIT: begin
				if (link.rd_valid) begin
					nxt_value = link.rd_data;
					nxt_state = CRS_H_RESUME;
				end
			end
			CRS_H_RESUME: begin
				nxt_pwr   = 1'b0;
				nxt_busy  = 1'b0;
				nxt_done  = 1'b1;
				nxt_state = CRS_H_IDLE;
			end
			default: begin
				nxt_state = CRS_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff  <= CRS_H_IDLE;
			settle_ff <= '0;
			mode_ff   <= CRS_STOP_NONE;
			sel_ff    <= 1'b0;
			req_ff    <= 1'b0;
			busy_ff   <= 1'b0;
			done_ff   <= 1'b0;
			value_ff  <= CNT_ZERO;
			pwr_ff    <= 1'b0;
			src_ff    <= '0;
			en_ff     <= '0;
		end else begin
			state_ff  <= nxt_state;
			settle_ff <= nxt_settle;
			mode_ff   <= nxt_mode;
			sel_ff    <= nxt_sel;
			req_ff    <= nxt_req;
			busy_ff   <= nxt_busy;
			done_ff   <= nxt_done;
			value_ff  <= nxt_value;
			pwr_ff    <= nxt_pwr;
			src_ff    <= nxt_src;
			en_ff     <= nxt_en;
		end
	end

	assign link.osc_pwr_down = pwr_ff;
	assign link.clk_src_mtx  = src_ff;
	assign link.mtx_en       = en_ff;
	assign link.mtx_tick     = tick_ff;
	assign link.rd_req       = req_ff;
	assign link.rd_sel       = sel_ff;
	assign busy              = busy_ff;
	assign done              = done_ff;
	assign value             = value_ff;
endmodule : crs_host_end
`default_nettype wire

// ===== crs_link_properties.sv
/*
 * Checker for the counter read-snapshot link between the two ends.
 * Assumes it sits beside the link interface, all on one clk.
 */
`timescale 1ns/10ps
`default_nettype none
module crs_link_properties (
	input wire logic                         clk,
	input wire logic                         reset,
	input wire logic                         osc_pwr_down,
	input wire logic [crs_pkg::CHANNELS-1:0] clk_src_mtx,
	input wire logic [crs_pkg::CHANNELS-1:0] mtx_en,
	input wire logic [crs_pkg::CHANNELS-1:0] mtx_tick,
	input wire logic [crs_pkg::CHANNELS-1:0] cnt_reset,
	input wire logic                         rd_req,
	input wire logic                         rd_valid,
	input wire logic [crs_pkg::CNT_W-1:0]    rd_data,
	input wire logic [crs_pkg::CHANNELS-1:0] cnt_out
);
	import crs_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	read_answer_a: assert property (rd_req |-> ##2 rd_valid)
		else $error("read request not answered in two cycles");
	valid_cause_a: assert property (rd_valid |-> $past(rd_req, 2))
		else $error("read answer without request");
	data_hold_a: assert property (!rd_valid |-> $stable(rd_data))
		else $error("read data moved without answer");
	reset_quiet_a: assert property (cnt_reset[CH_TWO] && $past(cnt_reset[CH_TWO]) |-> !cnt_out[CH_TWO])
		else $error("underflow while counter held in reset");
	osc_halt_a: assert property ((osc_pwr_down && !clk_src_mtx[CH_TWO])[*4] |-> !cnt_out[CH_TWO])
		else $error("counter ran with oscillator stopped");
	src_ground_a: assert property ((clk_src_mtx[CH_TWO] && !mtx_en[CH_TWO])[*4] |-> !cnt_out[CH_TWO])
		else $error("counter ran with grounded clock");
	stop_hold_a: assert property (rd_req && osc_pwr_down |=> osc_pwr_down[*2])
		else $error("clock restarted before read answered");
	tick_pulse_a: assert property (mtx_tick[CH_TWO] |=> !mtx_tick[CH_TWO])
		else $error("matrix tick longer than one cycle");

	cover property (rd_valid);
	cover property (rd_req && osc_pwr_down);
	cover property (rd_req && clk_src_mtx[CH_TWO] && !mtx_en[CH_TWO]);
endmodule : crs_link_properties
`default_nettype wire

// ===== testbench.sv
/*
 * Self-checking bench joining device end and host end by the link.
 * Assumes a 10 MHz clk and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import crs_pkg::*;
	logic                           clk = 1'b0;
	logic                           reset = 1'b1;
	logic                           start = 1'b0;
	logic                           sel = 1'b0;
	crs_stop_t                      stop_mode = CRS_STOP_NONE;
	logic [CHANNELS-1:0]            src_mtx_cfg = 2'h3;
	logic [CHANNELS-1:0]            mtx_en_cfg = 2'h3;
	logic [CHANNELS-1:0]            ext_clk_pin = 2'h0;
	logic [CHANNELS-1:0]            reset_pin = 2'h0;
	logic [CHANNELS-1:0][CNT_W-1:0] period = '0;
	logic                           busy;
	logic                           done;
	logic [CNT_W-1:0]               value;
	logic [CHANNELS-1:0][CNT_W-1:0] count_value;
	int                             bad_count = 0;
	int                             num_checks = 0;
	int                             outs = 0;
	int                             since = 0;
	int                             last_gap = 0;

	crs_link_if link ();
	crs_device_end i_crs_device_end (.clk(clk), .reset(reset), .link(link),
		.period(period), .count_value(count_value));
	crs_host_end i_crs_host_end (.clk(clk), .reset(reset), .link(link), .start(start),
		.sel(sel), .stop_mode(stop_mode), .src_mtx_cfg(src_mtx_cfg),
		.mtx_en_cfg(mtx_en_cfg), .ext_clk_pin(ext_clk_pin), .reset_pin(reset_pin),
		.busy(busy), .done(done), .value(value));
	crs_link_properties i_crs_link_properties (.clk(clk), .reset(reset),
		.osc_pwr_down(link.osc_pwr_down), .clk_src_mtx(link.clk_src_mtx),
		.mtx_en(link.mtx_en), .mtx_tick(link.mtx_tick), .cnt_reset(link.cnt_reset),
		.rd_req(link.rd_req), .rd_valid(link.rd_valid), .rd_data(link.rd_data),
		.cnt_out(link.cnt_out));

	always #50 clk = ~clk;

	// Underflow count of the selected channel and gap between underflows of the first channel
	always @(negedge clk) begin
		if (link.cnt_out[sel] === 1'b1) outs++;
		if (link.cnt_out[CH_TWO] === 1'b1) begin
			last_gap <= since;
			since <= 1;
		end else begin
			since <= since + 1;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic ch, input crs_stop_t m);
		@(negedge clk);
		sel = ch;
		stop_mode = m;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		chk(16'(busy), 16'h0001);
		for (int i = 0; i < 40 && done !== 1'b1; i++) @(posedge clk) #1;
		chk(16'(done), 16'h0001);
		chk(16'(busy), 16'h0000);
	endtask : rd

	task automatic pulse(input logic ch);
		@(negedge clk) ext_clk_pin[ch] = 1'b1;
		repeat (3) @(negedge clk);
		ext_clk_pin[ch] = 1'b0;
		repeat (3) @(negedge clk);
	endtask : pulse

	task automatic mtx_run(input logic ch, input logic [7:0] p, input int n, input crs_stop_t m);
		logic [7:0] e;
		int         base;
		e = p - 8'(n % (p + 1));
		@(negedge clk);
		period[ch] = p;
		sel = ch;
		reset_pin[ch] = 1'b1;
		@(posedge clk) #1 chk(16'(link.cnt_reset[ch]), 16'h0000);
		@(posedge clk) #1 chk(16'(link.cnt_reset[ch]), 16'h0001);
		pulse(ch);
		@(negedge clk) reset_pin[ch] = 1'b0;
		repeat (4) @(negedge clk);
		base = outs;
		repeat (n) pulse(ch);
		chk(16'(outs - base), 16'(n / (p + 1)));
		chk(16'(count_value[ch]), 16'(e));
		// Matrix edge during a stopped read must be lost
		fork
			rd(ch, m);
			if (m >= CRS_STOP_SRC) begin
				repeat (2) @(negedge clk);
				pulse(ch);
			end
		join
		chk(16'(value), 16'(e));
		pulse(ch);
		rd(ch, CRS_STOP_NONE);
		chk(16'(value), 16'((e == 8'h00) ? p : e - 8'h01));
	endtask : mtx_run

	task automatic osc_run();
		@(negedge clk);
		src_mtx_cfg = 2'h2;
		period[CH_TWO] = 8'h02;
		repeat (3) @(posedge clk iff link.cnt_out[CH_TWO] === 1'b1);
		#1 chk(16'(last_gap), 16'h000C);
		rd(CH_TWO, CRS_STOP_OSC);
		@(posedge clk iff link.cnt_out[CH_TWO] === 1'b1);
		#1 chk(16'(last_gap > 12 && last_gap < 26), 16'h0001);
	endtask : osc_run

	task automatic report_and_stop();
		if (bad_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		for (int m = 0; m < 4; m++) begin
			mtx_run(m[0], 8'h05 + 8'(m), 7 + 3 * m, crs_stop_t'(m[1:0]));
		end
		osc_run();
		report_and_stop();
	end

	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
